// *** hdl/tsps_map.svh ***
`ifndef TSPS_MAP_SVH
`define TSPS_MAP_SVH
`define TSPS_A_CTRL  6'h00
`define TSPS_A_SOAK  6'h04
`define TSPS_A_BAND  6'h08
`define TSPS_A_SP    6'h0C
`define TSPS_A_LIM   6'h10
`define TSPS_A_MVA   6'h14
`define TSPS_A_MVE   6'h18
`define TSPS_A_ASN   6'h1C
`define TSPS_A_CMD   6'h20
`define TSPS_A_STAT  6'h24
`define TSPS_A_REM   6'h28
`define TSPS_F_PAT   1:0
`define TSPS_F_PROGRAM_RUN_REQUEST  2
`define TSPS_F_EVASN 3
`define TSPS_F_HVAR  4
`define TSPS_F_MANL  5
`define TSPS_F_UNIT  7:6
`define TSPS_F_LO16  15:0
`define TSPS_F_HI16  31:16
`define TSPS_F_W14   13:0
`define TSPS_F_AUX1  1:0
`define TSPS_F_FIRST_ALARM_FUNCTION  3:2
`define TSPS_C_START 0
`define TSPS_C_CLEAR 1
`define TSPS_C_RUN   2
`define TSPS_C_STOP  3
`define TSPS_PAT_OFF  2'h0
`define TSPS_PAT_STOP 2'h1
`define TSPS_PAT_KEEP_RUNNING_PATTERN 2'h2
`define TSPS_ASN_NONE 2'h0
`define TSPS_ASN_FIRST_ALARM_FUNCTION 2'h1
`define TSPS_ASN_HA   2'h2
`define TSPS_ASN_PEND 2'h3
`define TSPS_U_MIN   2'h1
`define TSPS_U_HOUR  2'h2
`define TSPS_SUB_MIN  12'h03B
`define TSPS_SUB_HOUR 12'hE0F
`define TSPS_RST_SOAK 14'h0001
`define TSPS_RST_HI   16'h041A
`define TSPS_RST_LO   16'hFFCE
`define TSPS_CLK_MHZ  200
`define TSPS_HALF_MS  500
`define TSPS_OKAY     2'h0
`define TSPS_SLVERR   2'h2
`endif

// *** hdl/tsps_pkg.sv ***
package tsps_pkg;
  typedef logic signed [15:0] tsps_mv_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_RUN  = 2'h1,
    S_END  = 2'h3
  } tsps_seq_t;
  typedef struct packed {
    logic [1:0]  pat;
    logic        program_run_request;
    logic        ev_asn;
    logic        hvar;
    logic        manl;
    logic [1:0]  unit;
    logic [13:0] soak;
    logic [13:0] band;
    tsps_mv_t    sp;
    tsps_mv_t    hi;
    tsps_mv_t    lo;
    tsps_mv_t    mman;
    tsps_mv_t    mstop;
    tsps_mv_t    merr;
    logic [1:0]  aux1;
    logic [1:0]  first_alarm_function;
    logic        run;
    tsps_seq_t   seq;
    logic [13:0] cnt;
    logic [11:0] sub;
    logic [26:0] hcnt;
    logic        half;
    logic        nvw;
    tsps_mv_t    mv;
    logic        aux1_q;
    logic        first_alarm_function_q;
    logic        awg;
    logic        wg;
    logic [5:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
  } tsps_state_t;
endpackage

// *** hdl/tsps_top.sv ***
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "tsps_map.svh"
module tsps_top #(
  parameter int unsigned HALF_CYC =
    `TSPS_HALF_MS * `TSPS_CLK_MHZ * 1000
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // AXI4-Lite write
  input  wire logic [5:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [5:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Process values
  input  wire tsps_pkg::tsps_mv_t pv,
  input  wire logic              pv_error,
  input  wire tsps_pkg::tsps_mv_t calc_mv,
  input  wire logic              manual_mode,
  // Events and alarm sources
  input  wire logic              event_in,
  input  wire logic              end_clear_evt,
  input  wire logic              alarm1_in,
  input  wire logic              heater_alarm_in,
  // Outputs
  output tsps_pkg::tsps_mv_t     mv_out,
  output logic                   run_out,
  output logic                   program_end_out,
  output logic                   aux1_out,
  output logic                   alarm1_out,
  output logic                   disp2_end,
  output logic                   nvm_write
);
  import tsps_pkg::*;

  tsps_state_t st_reg;
  tsps_state_t st_next;
  logic        wr_fire;
  logic [31:0] wmrg;
  logic [31:0] rmux;
  logic        in_band;
  logic        sec_tick;
  logic        rise;
  logic        fall;
  logic signed [16:0] diff;
  logic [16:0] adiff;

  // Byte lanes merged onto the current word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Output assignment selector
  function automatic logic pick(
    input logic [1:0] sel,
    input logic       a1,
    input logic       ha,
    input logic       pe
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      `TSPS_ASN_NONE: r = 1'b0;
      `TSPS_ASN_FIRST_ALARM_FUNCTION: r = a1;
      `TSPS_ASN_HA:   r = ha;
      `TSPS_ASN_PEND: r = pe;
    endcase
    return r;
  endfunction

  // Handshakes straight from state
  assign s_axi_awready = !st_reg.awg && !st_reg.bv;
  assign s_axi_wready  = !st_reg.wg && !st_reg.bv;
  assign s_axi_arready = !st_reg.rv;
  assign wr_fire = st_reg.awg && st_reg.wg && !st_reg.bv;

  // Registered data outputs
  assign s_axi_bvalid    = st_reg.bv;
  assign s_axi_bresp     = st_reg.br;
  assign s_axi_rvalid    = st_reg.rv;
  assign s_axi_rdata     = st_reg.rd;
  assign s_axi_rresp     = st_reg.rr;
  assign mv_out          = st_reg.mv;
  assign run_out         = st_reg.run;
  assign program_end_out = st_reg.seq == S_END;
  assign aux1_out        = st_reg.aux1_q;
  assign alarm1_out      = st_reg.first_alarm_function_q;
  assign nvm_write       = st_reg.nvw;
  // Alternate set point and end mark
  assign disp2_end = (st_reg.seq == S_END) && st_reg.half;

  // Band test; wide diff avoids wrap
  assign diff  = {pv[15], pv} - {st_reg.sp[15], st_reg.sp};
  assign adiff = diff[16] ? 17'(-diff) : 17'(diff);
  assign in_band = (st_reg.band == 14'h0000) ||
                   (adiff <= {3'h0, st_reg.band});

  // Second tick at end of every second half
  assign sec_tick = st_reg.half &&
    (st_reg.hcnt == 27'(HALF_CYC - 1));

  assign wmrg = merge(32'h0000_0000, st_reg.wd, st_reg.ws);

  // Read view of registers
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (s_axi_araddr)
      `TSPS_A_CTRL: begin
        rmux[`TSPS_F_PAT]   = st_reg.pat;
        rmux[`TSPS_F_PROGRAM_RUN_REQUEST]  = st_reg.program_run_request;
        rmux[`TSPS_F_EVASN] = st_reg.ev_asn;
        rmux[`TSPS_F_HVAR]  = st_reg.hvar;
        rmux[`TSPS_F_MANL]  = st_reg.manl;
        rmux[`TSPS_F_UNIT]  = st_reg.unit;
      end
      `TSPS_A_SOAK: rmux[`TSPS_F_W14] = st_reg.soak;
      `TSPS_A_BAND: rmux[`TSPS_F_W14] = st_reg.band;
      `TSPS_A_SP:   rmux[`TSPS_F_LO16] = st_reg.sp;
      `TSPS_A_LIM:  rmux = {st_reg.lo, st_reg.hi};
      `TSPS_A_MVA:  rmux = {st_reg.mstop, st_reg.mman};
      `TSPS_A_MVE:  rmux[`TSPS_F_LO16] = st_reg.merr;
      `TSPS_A_ASN: begin
        rmux[`TSPS_F_AUX1] = st_reg.aux1;
        rmux[`TSPS_F_FIRST_ALARM_FUNCTION] = st_reg.first_alarm_function;
      end
      `TSPS_A_STAT: begin
        rmux[0] = st_reg.run;
        rmux[1] = st_reg.seq == S_END;
        rmux[2] = st_reg.seq == S_RUN;
        rmux[3] = st_reg.program_run_request;
      end
      `TSPS_A_REM: begin
        rmux[`TSPS_F_W14] = (st_reg.seq == S_RUN) ?
          14'(st_reg.soak - st_reg.cnt) : 14'h0000;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.nvw = 1'b0;
    rise = 1'b0;
    fall = 1'b0;

    // Address and data may come in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.awg = 1'b1;
      st_next.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.wg = 1'b1;
      st_next.wd = s_axi_wdata;
      st_next.ws = s_axi_wstrb;
    end
    if (st_reg.bv && s_axi_bready) begin
      st_next.bv = 1'b0;
    end

    // Register write once both halves are held
    if (wr_fire) begin
      st_next.awg = 1'b0;
      st_next.wg  = 1'b0;
      st_next.bv  = 1'b1;
      st_next.br  = `TSPS_OKAY;
      unique case (st_reg.awa)
        `TSPS_A_CTRL: begin
          if (st_reg.ws[0]) begin
            st_next.pat    = st_reg.wd[`TSPS_F_PAT];
            st_next.ev_asn = st_reg.wd[`TSPS_F_EVASN];
            st_next.hvar   = st_reg.wd[`TSPS_F_HVAR];
            st_next.manl   = st_reg.wd[`TSPS_F_MANL];
            st_next.unit   = st_reg.wd[`TSPS_F_UNIT];
            // Key change refused while mirroring
            if (!st_reg.ev_asn) begin
              st_next.program_run_request = st_reg.wd[`TSPS_F_PROGRAM_RUN_REQUEST];
            end
          end
        end
        `TSPS_A_SOAK: st_next.soak = 14'(merge(
          {18'h0, st_reg.soak}, st_reg.wd, st_reg.ws));
        `TSPS_A_BAND: st_next.band = 14'(merge(
          {18'h0, st_reg.band}, st_reg.wd, st_reg.ws));
        `TSPS_A_SP: st_next.sp = 16'(merge(
          {16'h0, st_reg.sp}, st_reg.wd, st_reg.ws));
        `TSPS_A_LIM: {st_next.lo, st_next.hi} = merge(
          {st_reg.lo, st_reg.hi}, st_reg.wd, st_reg.ws);
        `TSPS_A_MVA: {st_next.mstop, st_next.mman} = merge(
          {st_reg.mstop, st_reg.mman}, st_reg.wd, st_reg.ws);
        `TSPS_A_MVE: st_next.merr = 16'(merge(
          {16'h0, st_reg.merr}, st_reg.wd, st_reg.ws));
        `TSPS_A_ASN: begin
          if (st_reg.ws[0]) begin
            st_next.aux1 = st_reg.wd[`TSPS_F_AUX1];
            st_next.first_alarm_function = st_reg.wd[`TSPS_F_FIRST_ALARM_FUNCTION];
          end
        end
        `TSPS_A_CMD: begin
          // Comms start only without event owner
          if (!st_reg.ev_asn &&
              wmrg[`TSPS_C_START]) begin
            st_next.program_run_request = 1'b1;
          end
          if (!st_reg.ev_asn &&
              wmrg[`TSPS_C_CLEAR]) begin
            st_next.program_run_request = 1'b0;
          end
          if (wmrg[`TSPS_C_RUN]) begin
            st_next.run = 1'b1;
          end
          if (wmrg[`TSPS_C_STOP]) begin
            st_next.run = 1'b0;
          end
        end
        `TSPS_A_STAT,
        `TSPS_A_REM: st_next.br = `TSPS_OKAY;
        default: st_next.br = `TSPS_SLVERR;
      endcase
    end

    // Read answer one cycle after address
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rv = 1'b1;
      st_next.rd = rmux;
      st_next.rr = `TSPS_OKAY;
      if (!(s_axi_araddr inside {`TSPS_A_CTRL,
          `TSPS_A_SOAK, `TSPS_A_BAND, `TSPS_A_SP,
          `TSPS_A_LIM, `TSPS_A_MVA, `TSPS_A_MVE,
          `TSPS_A_ASN, `TSPS_A_CMD, `TSPS_A_STAT,
          `TSPS_A_REM})) begin
        st_next.rr = `TSPS_SLVERR;
      end
    end
    if (st_reg.rv && s_axi_rready) begin
      st_next.rv = 1'b0;
    end

    // Pattern edges retarget output assignments
    if (st_reg.pat == `TSPS_PAT_OFF &&
        st_next.pat != `TSPS_PAT_OFF) begin
      st_next.aux1 = `TSPS_ASN_PEND;
    end
    if (st_reg.pat != `TSPS_PAT_OFF &&
        st_next.pat == `TSPS_PAT_OFF) begin
      st_next.first_alarm_function = st_next.hvar ?
        `TSPS_ASN_HA : `TSPS_ASN_FIRST_ALARM_FUNCTION;
    end
    if (st_next.pat == `TSPS_PAT_OFF) begin
      st_next.ev_asn = 1'b0;
    end

    // Event owner drives the start setting
    if (st_next.ev_asn) begin
      st_next.program_run_request = event_in;
    end
    rise = st_next.program_run_request && !st_reg.program_run_request;
    fall = !st_next.program_run_request && st_reg.program_run_request;

    // Half-second phase for the end display
    if (st_reg.hcnt == 27'(HALF_CYC - 1)) begin
      st_next.hcnt = 27'h0;
      st_next.half = !st_reg.half;
    end else begin
      st_next.hcnt = st_reg.hcnt + 27'h1;
    end

    // Start and reset of the program
    if (rise && st_next.pat != `TSPS_PAT_OFF) begin
      st_next.seq = S_RUN;
      st_next.cnt = 14'h0000;
      st_next.sub = 12'h000;
      st_next.run = 1'b1;
      st_next.nvw = 1'b1;
    end else if (fall) begin
      // Each start and reset costs a store
      st_next.nvw = 1'b1;
      if (st_reg.seq == S_RUN) begin
        st_next.run = 1'b0;
      end
      st_next.seq = S_IDLE;
    end

    // Event clears the end status as well
    if (st_next.seq == S_END && end_clear_evt) begin
      st_next.seq = S_IDLE;
    end

    // Soak runs regardless of run/stop state
    if (st_reg.seq == S_RUN && st_next.seq == S_RUN &&
        in_band && sec_tick) begin
      if ((st_reg.unit == `TSPS_U_MIN &&
           st_reg.sub != `TSPS_SUB_MIN) ||
          (st_reg.unit == `TSPS_U_HOUR &&
           st_reg.sub != `TSPS_SUB_HOUR)) begin
        st_next.sub = st_reg.sub + 12'h001;
      end else begin
        st_next.sub = 12'h000;
        st_next.cnt = st_reg.cnt + 14'h0001;
        // End is set after the event clear, so it wins
        if (st_next.cnt >= st_reg.soak) begin
          st_next.seq = S_END;
          // Continue pattern leaves run untouched
          if (st_reg.pat == `TSPS_PAT_STOP) begin
            st_next.run = 1'b0;
          end
        end
      end
    end

    // No program at all with pattern off
    if (st_next.pat == `TSPS_PAT_OFF) begin
      st_next.seq = S_IDLE;
    end

    // Assigned outputs follow their function
    st_next.aux1_q = pick(st_reg.aux1, alarm1_in,
      heater_alarm_in, st_reg.seq == S_END);
    st_next.first_alarm_function_q = pick(st_reg.first_alarm_function, alarm1_in,
      heater_alarm_in, st_reg.seq == S_END);

    // Fixed values first, then the one limit pair
    if (manual_mode) begin
      st_next.mv = st_reg.mman;
      if (st_reg.manl) begin
        if (st_reg.mman > st_reg.hi) begin
          st_next.mv = st_reg.hi;
        end else if (st_reg.mman < st_reg.lo) begin
          st_next.mv = st_reg.lo;
        end
      end
    end else if (!st_reg.run) begin
      st_next.mv = st_reg.mstop;
    end else if (pv_error) begin
      st_next.mv = st_reg.merr;
    end else if (calc_mv > st_reg.hi) begin
      st_next.mv = st_reg.hi;
    end else if (calc_mv < st_reg.lo) begin
      st_next.mv = st_reg.lo;
    end else begin
      st_next.mv = calc_mv;
    end
  end

  // Single state register; ce freezes it all
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= '0;
      st_reg.soak <= `TSPS_RST_SOAK;
      st_reg.hi   <= `TSPS_RST_HI;
      st_reg.lo   <= `TSPS_RST_LO;
      st_reg.seq  <= S_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Checks on the sequencer, output assignments and MV limit
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_pattern_off_idle: assert property (
    st_reg.pat == `TSPS_PAT_OFF |-> st_reg.seq == S_IDLE)
    else $error("program active with pattern off");

  a_stop_at_end: assert property (
    ce && st_reg.seq == S_RUN && st_next.seq == S_END &&
    st_reg.pat == `TSPS_PAT_STOP |=> !st_reg.run)
    else $error("stop pattern did not stop control");

  a_keep_running_pattern_at_end: assert property (
    ce && st_reg.seq == S_RUN && st_next.seq == S_END &&
    st_reg.pat == `TSPS_PAT_KEEP_RUNNING_PATTERN && st_reg.run &&
    !(wr_fire && st_reg.awa == `TSPS_A_CMD)
    |=> st_reg.run)
    else $error("continue pattern left run mode");

  a_event_mirror: assert property (
    ce && st_next.ev_asn |=> st_reg.program_run_request == $past(event_in))
    else $error("start setting does not mirror event");

  a_off_clears_asn: assert property (
    st_reg.pat == `TSPS_PAT_OFF |-> !st_reg.ev_asn)
    else $error("event assignment kept with pattern off");

  a_soak_pause: assert property (
    ce && st_reg.seq == S_RUN && !in_band
    |=> st_reg.cnt == $past(st_reg.cnt))
    else $error("soak counted outside wait band");

  a_start_runs: assert property (
    ce && rise && st_next.pat != `TSPS_PAT_OFF
    |=> st_reg.run && st_reg.seq == S_RUN &&
        st_reg.cnt == 14'h0000 && st_reg.nvw)
    else $error("start did not force run");

  a_early_reset: assert property (
    ce && fall && st_reg.seq == S_RUN
    |=> !st_reg.run && st_reg.seq == S_IDLE)
    else $error("early reset did not abandon");

  a_end_clear: assert property (
    ce && fall && st_reg.seq == S_END
    |=> !program_end_out ##1 !disp2_end)
    else $error("end output kept after reset");

  a_aux1_auto: assert property (
    st_reg.pat != `TSPS_PAT_OFF &&
    $past(st_reg.pat) == `TSPS_PAT_OFF
    |-> st_reg.aux1 == `TSPS_ASN_PEND)
    else $error("aux output 1 not given end signal");

  a_mv_upper: assert property (
    ce && !manual_mode && st_reg.run && !pv_error &&
    calc_mv > st_reg.hi |=> mv_out == $past(st_reg.hi))
    else $error("calculated value above upper limit");

  c_end_stop: cover property (
    st_reg.seq == S_RUN ##1 st_reg.seq == S_END);
  c_abandon: cover property (
    st_reg.seq == S_RUN ##1 st_reg.seq == S_IDLE);
  c_evt_clear: cover property (
    st_reg.seq == S_END && end_clear_evt && ce);
endmodule

// *** verif/tsps_plant_model.sv ***
`timescale 1ns/1ps
module tsps_plant_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Levels requested by the bench, and the store strobe from the device
  input  wire tsps_pkg::tsps_mv_t pv_req,
  input  wire logic               ev_req,
  input  wire logic               clr_req,
  input  wire logic               ha_req,
  input  wire logic               nvm_write,
  // Field lines toward the device, and the store count for the bench
  output tsps_pkg::tsps_mv_t      pv,
  output logic                    event_in,
  output logic                    end_clear_evt,
  output logic                    alarm1_in,
  output logic                    heater_alarm_in,
  output int unsigned             nvm_cnt
);
  import tsps_pkg::*;

  // Field levels move one edge after a request, like a scanned input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pv              <= 16'h0000;
      event_in        <= 1'b0;
      end_clear_evt   <= 1'b0;
      alarm1_in       <= 1'b0;
      heater_alarm_in <= 1'b0;
    end else begin
      pv              <= pv_req;
      event_in        <= ev_req;
      end_clear_evt   <= clr_req;
      heater_alarm_in <= ha_req;
      alarm1_in       <= !ha_req; // Opposite level tells sources apart
    end
  end

  // Stored writes; the plant keeps starts and resets well under endurance
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nvm_cnt <= 0;
    end else if (nvm_write && nvm_cnt < 1000000) begin
      nvm_cnt <= nvm_cnt + 1;
    end
  end
endmodule

// *** verif/tsps_tb_top.sv ***
`timescale 1ns/1ps
`include "tsps_map.svh"
module tsps_tb_top;
  import tsps_pkg::*;
  // Short half period: one soak second is 8 cycles
  localparam int CEIL = 20000;
  logic        clk = 1'b0, nrst = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rdat;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bres, rres;
  tsps_mv_t    pv, mv_out, calc_mv = 16'h0000, pv_req = 16'h0064;
  logic        pv_error = 1'b0, manual_mode = 1'b0, ev_req = 1'b0;
  logic        clr_req = 1'b0, ha_req = 1'b0, prev, ce = 1'b1;
  logic        event_in, end_clear_evt, alarm1_in, heater_alarm_in;
  logic        run_out, program_end_out, aux1_out, alarm1_out;
  logic        disp2_end, nvm_write;
  int unsigned nvm_cnt;
  int          mismatches = 0, compares = 0, cycles = 0, k;

  tsps_top #(.HALF_CYC(4)) dut (
    .clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pv(pv), .pv_error(pv_error),
    .calc_mv(calc_mv), .manual_mode(manual_mode), .event_in(event_in),
    .end_clear_evt(end_clear_evt), .alarm1_in(alarm1_in),
    .heater_alarm_in(heater_alarm_in), .mv_out(mv_out),
    .run_out(run_out), .program_end_out(program_end_out),
    .aux1_out(aux1_out), .alarm1_out(alarm1_out),
    .disp2_end(disp2_end), .nvm_write(nvm_write));

  tsps_plant_model plant (
    .clk(clk), .nrst(nrst), .pv_req(pv_req), .ev_req(ev_req),
    .clr_req(clr_req), .ha_req(ha_req), .nvm_write(nvm_write), .pv(pv),
    .event_in(event_in), .end_clear_evt(end_clear_evt),
    .alarm1_in(alarm1_in), .heater_alarm_in(heater_alarm_in),
    .nvm_cnt(nvm_cnt));

  always #2.5 clk = ~clk;

  // Hang guard; counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk1(input string n, input logic s, e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Handshakes judged mid-cycle; stable until the next rising edge
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic ag, wg, bg;
    bg = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!bg) begin
      @(negedge clk);
      ag = s_axi_awvalid && s_axi_awready;
      wg = s_axi_wvalid && s_axi_wready;
      bg = s_axi_bvalid;
      bres = s_axi_bresp;
      @(posedge clk);
      if (ag) s_axi_awvalid <= 1'b0;
      if (wg) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    logic ag, rg;
    rg = 1'b0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!rg) begin
      @(negedge clk);
      ag = s_axi_arvalid && s_axi_arready;
      rg = s_axi_rvalid;
      rdat = s_axi_rdata;
      rres = s_axi_rresp;
      @(posedge clk);
      if (ag) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_end(input logic v, input int lim);
    k = 0;
    // First look mid-cycle, never on the launching edge
    @(negedge clk);
    while (program_end_out !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk1("end", program_end_out, v);
  endtask

  task automatic set_pv(input tsps_mv_t v);
    @(posedge clk);
    pv_req <= v;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Reset values and unmapped slots
    rd(`TSPS_A_CTRL); chk("ctrl", rdat, 32'h00000000);
    rd(`TSPS_A_SOAK); chk("soak", rdat, 32'h00000001);
    rd(`TSPS_A_LIM); chk("lim", rdat, 32'hFFCE041A);
    rd(6'h2C); chk("rresp", {30'h0, rres}, {30'h0, `TSPS_SLVERR});
    wr(6'h30, 32'hFFFFFFFF); chk("bresp", {30'h0, bres}, 32'h2);
    // Start request with the pattern off
    wr(`TSPS_A_CTRL, 32'h00000004);
    settle(6); chk1("run off", run_out, 1'b0);
    wr(`TSPS_A_CTRL, 32'h00000000);
    wr(`TSPS_A_CTRL, 32'h00000001);
    rd(`TSPS_A_ASN); chk("asn on", rdat, 32'h00000003);
    // Soak held off while outside the band
    wr(`TSPS_A_SOAK, 32'h00000003);
    wr(`TSPS_A_BAND, 32'h00000005);
    wr(`TSPS_A_SP, 32'h00000064);
    set_pv(16'h012C);
    wr(`TSPS_A_CTRL, 32'h00000005);
    settle(4); chk1("run start", run_out, 1'b1);
    settle(40); chk1("end held", program_end_out, 1'b0);
    set_pv(16'h0066);
    wait_end(1'b1, 40);
    chk1("stop at end", run_out, 1'b0);
    settle(1);
    chk1("aux1 end", aux1_out, 1'b1);
    rd(`TSPS_A_STAT); chk1("stat end", rdat[1], 1'b1);
    k = 0;
    prev = disp2_end;
    repeat (40) begin
      @(negedge clk);
      if (disp2_end !== prev) k++;
      prev = disp2_end;
    end
    chk1("disp2 blink", k >= 9 && k <= 11, 1'b1);
    wr(`TSPS_A_CTRL, 32'h00000001);
    settle(4); chk1("end cleared", program_end_out, 1'b0);
    // Pause outside band and operator stop keep the count
    wr(`TSPS_A_SOAK, 32'h00000008);
    set_pv(16'h0064);
    wr(`TSPS_A_CTRL, 32'h00000005);
    settle(30);
    set_pv(16'h012C);
    wr(`TSPS_A_CMD, 32'h00000008);
    settle(4); chk1("op stop", run_out, 1'b0);
    settle(60); chk1("paused", program_end_out, 1'b0);
    wr(`TSPS_A_CMD, 32'h00000004);
    set_pv(16'h0064);
    wait_end(1'b1, 48);
    wr(`TSPS_A_CTRL, 32'h00000001);
    // Band off, continue pattern
    wr(`TSPS_A_SOAK, 32'h00000003);
    wr(`TSPS_A_BAND, 32'h00000000);
    set_pv(16'h7000);
    wr(`TSPS_A_CTRL, 32'h00000006);
    wait_end(1'b1, 40);
    chk1("keep_running_pattern run", run_out, 1'b1);
    @(posedge clk);
    clr_req <= 1'b1;
    settle(4); chk1("evt clear", program_end_out, 1'b0);
    @(posedge clk);
    clr_req <= 1'b0;
    wr(`TSPS_A_CTRL, 32'h00000002);
    // Minute unit: sixty second ticks per count
    wr(`TSPS_A_SOAK, 32'h00000001);
    wr(`TSPS_A_CTRL, 32'h00000046);
    settle(400); chk1("min held", program_end_out, 1'b0);
    wait_end(1'b1, 120);
    wr(`TSPS_A_CTRL, 32'h00000042);
    // Early reset abandons the program
    wr(`TSPS_A_SOAK, 32'h00000064);
    wr(`TSPS_A_CTRL, 32'h00000006);
    settle(20);
    wr(`TSPS_A_CTRL, 32'h00000002);
    settle(4); chk1("abandon", run_out, 1'b0);
    wr(`TSPS_A_CMD, 32'h00000001);
    settle(4); chk1("comms start", run_out, 1'b1);
    wr(`TSPS_A_CMD, 32'h00000002);
    settle(4); chk1("comms clear", run_out, 1'b0);
    // Event assigned: setting mirrors it, keys and comms refused
    wr(`TSPS_A_CTRL, 32'h0000000A);
    @(posedge clk);
    ev_req <= 1'b1;
    settle(6); chk1("evt start", run_out, 1'b1);
    wr(`TSPS_A_CTRL, 32'h0000000A);
    rd(`TSPS_A_STAT); chk1("mirror", rdat[3], 1'b1);
    @(posedge clk);
    ev_req <= 1'b0;
    settle(6); chk1("evt reset", run_out, 1'b0);
    wr(`TSPS_A_CMD, 32'h00000001);
    settle(4); chk1("comms refused", run_out, 1'b0);
    wr(`TSPS_A_CTRL, 32'h0000000E);
    settle(4); chk1("key refused", run_out, 1'b0);
    // Pattern off: assignment cleared, alarm output restored
    wr(`TSPS_A_CTRL, 32'h00000018);
    rd(`TSPS_A_CTRL); chk("ctrl off", rdat, 32'h00000010);
    rd(`TSPS_A_ASN); chk("asn off", rdat, 32'h0000000B);
    @(posedge clk);
    ha_req <= 1'b1;
    settle(4); chk1("alarm1 route", alarm1_out, 1'b1);
    // Output priority and limits
    wr(`TSPS_A_MVA, 32'h00320500);
    wr(`TSPS_A_MVE, 32'h00000014);
    settle(3); chk("mv stop", mv_out, 32'h00000032);
    @(posedge clk);
    manual_mode <= 1'b1;
    settle(3); chk("mv man", mv_out, 32'h00000500);
    wr(`TSPS_A_CTRL, 32'h00000030);
    settle(3); chk("mv man lim", mv_out, 32'h0000041A);
    @(posedge clk);
    manual_mode <= 1'b0;
    calc_mv <= 16'h0600;
    wr(`TSPS_A_CMD, 32'h00000004);
    settle(4); chk("mv hi", mv_out, 32'h0000041A);
    @(posedge clk);
    calc_mv <= 16'hFF00;
    settle(3); chk("mv lo", {16'h0, mv_out}, 32'h0000FFCE);
    @(posedge clk);
    pv_error <= 1'b1;
    settle(3); chk("mv err", mv_out, 32'h00000014);
    // Clock enable low freezes every register
    @(posedge clk);
    ce <= 1'b0;
    pv_error <= 1'b0;
    settle(3); chk("mv frozen", mv_out, 32'h00000014);
    @(posedge clk);
    ce <= 1'b1;
    settle(3); chk("mv thawed", {16'h0, mv_out}, 32'h0000FFCE);
    chk1("nvm used", nvm_cnt > 0, 1'b1);
    final_report();
  end
endmodule
